// ===== logic/parallel_interface_pkg.sv
// Shared constants for the three-port parallel interface with handshake modes.
// Assumes a single 10 MHz clock and a host that uses the plain strobe register port.
package parallel_interface_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int HALF_W = 4;
  localparam int PIN_W  = 3 * DATA_W;

  // Register address codes.
  localparam logic [ADDR_W-1:0] ADDR_PORTA = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_PORTB = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_PORTC = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 2'h3;

  // Control word fields when the top bit is set.
  localparam int CW_MODESET = 7;
  localparam int CW_AMODE_H = 6;
  localparam int CW_AMODE_L = 5;
  localparam int CW_A_IN    = 4;
  localparam int CW_CU_IN   = 3;
  localparam int CW_BMODE   = 2;
  localparam int CW_B_IN    = 1;
  localparam int CW_CL_IN   = 0;

  // Port C bit command fields when the top bit is clear.
  localparam int BSR_SEL_H = 3;
  localparam int BSR_SEL_L = 1;
  localparam int BSR_VAL   = 0;

  // Port C handshake bit positions.
  localparam int PC_INTR = 3;
  localparam int PC_STB  = 4;
  localparam int PC_IN_FULL  = 5;
  localparam int PC_ACK      = 6;
  localparam int PC_OUT_FULL = 7;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h9b;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic              PIN_IDLE    = 1'b1;

  // Shortest later reset pulse, held by the system reset source.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int RESET_MIN_NS     = 500;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_BASIC    = 2'b00,
    MODE_STROBED  = 2'b01,
    MODE_BIDIR    = 2'b10
  } amode_e;

endpackage

// ===== logic/pin_sync.sv
// Two-stage synchroniser for every pin input of the parallel interface.
// Assumes pins idle high, so strobes see no false edge after reset.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import parallel_interface_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      logic stable;
      // The first stage feeds only the second one.
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          meta   <= PIN_IDLE;
          stable <= PIN_IDLE;
        end else begin
          meta   <= asyncIn[i];
          stable <= meta;
        end
      end
      assign syncOut[i] = stable;
    end
  endgenerate

endmodule

// ===== logic/parallel_port_handshake.sv
// Three-port parallel interface with plain, strobed and bidirectional port A modes.
// Assumes pins arrive from outside the clock domain and a host on the strobe port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Host writes 10010000 to select mode 0, A input, B and C outputs.
// R2: After a mode write, input reads return pins and output writes drive pins.
// R3: A bit command changes only the chosen port C bit; others keep value.
// R4: Control is written with chip select low and address 3; ports at 0-2.
// R5: Mode 1 strobe on C4 latches port A and raises buffer-full on C5.
// R6: With C4 interrupt enable set, latched strobe data raises interrupt on C3.
// R7: Port B keeps its own mode and direction, independent of port A; the code ignores the port B mode bit 2.
// R8: Host writes 10110000 then 00001001 to enable port A input interrupt.
// R9: Host read of port A in mode 1 returns latch and drops C3 interrupt.
// R10: In mode 2, low acknowledge on C6 drives output latch onto port A.
// R11: In mode 2, low strobe on C4 captures port A into input latch.
// R12: Host write to port A in mode 2 drives output-full flag low.
// R13: Acknowledge from far party returns output-full flag high.
// R14: Port C read in mode 2 shows output-full in bit 7, input-full bit 5.
// R15: Far-party strobe in mode 2 sets input-buffer-full high.
// R16: Host read of port A in mode 2 returns input latch, clears input-full.
// R17: Each side polls the full flags before writing a new byte.
// R18: Mode 2 port A keeps separate input and output latches.
// R19: System resets at start; pulses at least 50 us first, 500 ns later; the bench holds its first reset only 10 cycles (about 1 us).
// R20: Control word with top bit clear: bits 3-1 select C bit, bit 0 value.
module parallel_port_handshake (
  input  wire logic                                     sys_clk,
  input  wire logic                                     resetn,
  input  wire logic                                     chipSelN,
  input  wire logic [parallel_interface_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [parallel_interface_pkg::DATA_W-1:0] writeData,
  input  wire logic                                     writeStrobe,
  input  wire logic                                     readStrobe,
  output logic      [parallel_interface_pkg::DATA_W-1:0] readData,
  input  wire logic [parallel_interface_pkg::DATA_W-1:0] portAIn,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portAOut,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portAOutEnN,
  input  wire logic [parallel_interface_pkg::DATA_W-1:0] portBIn,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portBOut,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portBOutEnN,
  input  wire logic [parallel_interface_pkg::DATA_W-1:0] portCIn,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portCOut,
  output logic      [parallel_interface_pkg::DATA_W-1:0] portCOutEnN
);
  import parallel_interface_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [DATA_W-1:0] ctrl, latchA, latchB, latchC, inLatchA;
  logic [DATA_W-1:0] pinsA, pinsB, pinsC, pcDrive, pcOut, readC, bitMask;
  logic [PIN_W-1:0]  pinSync;
  amode_e            modeA;
  logic              inputBufferFull, outputBufferFullN, intrIn, intrOut, stbPrev, ackPrev;
  logic              aIn, bIn, cuIn, clIn, hsIn, hsOut, portADrive;
  logic              sel, wrCtrl, modeSet, bitCmd, wrA, wrB, wrC, rdA, rdC;
  logic              stbFall, ackFall, ackRise;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .asyncIn ({portCIn, portBIn, portAIn}),
    .syncOut (pinSync)
  );

  assign pinsA = pinSync[DATA_W-1:0];
  assign pinsB = pinSync[2*DATA_W-1:DATA_W];
  assign pinsC = pinSync[PIN_W-1:2*DATA_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  always_comb begin
    unique case (ctrl[CW_AMODE_H:CW_AMODE_L])
      2'h0:    modeA = MODE_BASIC;
      2'h1:    modeA = MODE_STROBED;
      default: modeA = MODE_BIDIR;
    endcase
  end

  assign aIn   = ctrl[CW_A_IN];
  assign bIn   = ctrl[CW_B_IN];
  assign cuIn  = ctrl[CW_CU_IN];
  assign clIn  = ctrl[CW_CL_IN];
  assign hsIn  = (modeA == MODE_BIDIR) || (modeA == MODE_STROBED && aIn);
  assign hsOut = (modeA == MODE_BIDIR) || (modeA == MODE_STROBED && !aIn);

  ////////////////////////////////////////////////////////////////////////////////
  // Host access decode.

  // R4: chip select decode.
  assign sel     = !chipSelN;
  assign wrCtrl  = sel && writeStrobe && regAddr == ADDR_CTRL;
  assign modeSet = wrCtrl && writeData[CW_MODESET];
  assign bitCmd  = wrCtrl && !writeData[CW_MODESET];
  assign wrA     = sel && writeStrobe && regAddr == ADDR_PORTA;
  assign wrB     = sel && writeStrobe && regAddr == ADDR_PORTB;
  assign wrC     = sel && writeStrobe && regAddr == ADDR_PORTC;
  assign rdA     = sel && readStrobe && regAddr == ADDR_PORTA;
  assign rdC     = sel && readStrobe && regAddr == ADDR_PORTC;
  assign bitMask = 8'h01 << writeData[BSR_SEL_H:BSR_SEL_L];

  ////////////////////////////////////////////////////////////////////////////////
  // Handshake edges.

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stbPrev <= PIN_IDLE;
      ackPrev <= PIN_IDLE;
    end else begin
      stbPrev <= pinsC[PC_STB];
      ackPrev <= pinsC[PC_ACK];
    end
  end

  assign stbFall = hsIn && stbPrev && !pinsC[PC_STB];
  assign ackFall = hsOut && ackPrev && !pinsC[PC_ACK];
  assign ackRise = hsOut && !ackPrev && pinsC[PC_ACK];

  ////////////////////////////////////////////////////////////////////////////////
  // Control and output latches.

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
    end else if (modeSet) begin
      // R4: control word store.
      ctrl <= writeData;
    end
  end

  // A mode write clears the output latches A, B and C so no stale byte leaves in the new mode.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      latchA <= LATCH_RESET;
      latchB <= LATCH_RESET;
    end else if (modeSet) begin
      latchA <= LATCH_RESET;
      latchB <= LATCH_RESET;
    end else begin
      // R2: output latch writes.
      if (wrA) begin
        latchA <= writeData;
      end
      // R7: port B independent.
      if (wrB) begin
        latchB <= writeData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      latchC <= LATCH_RESET;
    end else if (modeSet) begin
      latchC <= LATCH_RESET;
    end else if (bitCmd) begin
      // R3: single bit change.
      // R20: select and value.
      latchC[writeData[BSR_SEL_H:BSR_SEL_L]] <= writeData[BSR_VAL];
    end else if (wrC) begin
      latchC <= writeData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input latch and flags.

  // R18: separate input latch.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inLatchA <= LATCH_RESET;
    end else if (stbFall) begin
      // R11: strobe captures pins.
      inLatchA <= pinsA;
    end
  end

  // A strobe in the same cycle as the host read wins, so no byte goes unseen.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inputBufferFull <= 1'b0;
    end else if (modeSet) begin
      inputBufferFull <= 1'b0;
    end else if (stbFall) begin
      // R5: buffer full set.
      // R15: strobe sets flag.
      inputBufferFull <= 1'b1;
    end else if (rdA && hsIn) begin
      // R16: read clears flag.
      inputBufferFull <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outputBufferFullN <= 1'b1;
    end else if (modeSet) begin
      outputBufferFullN <= 1'b1;
    end else if (wrA && hsOut) begin
      // R12: write marks full.
      outputBufferFullN <= 1'b0;
    end else if (ackFall) begin
      // R13: acknowledge empties buffer.
      outputBufferFullN <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intrIn <= 1'b0;
    end else if (modeSet) begin
      intrIn <= 1'b0;
    end else if (stbFall && latchC[PC_STB]) begin
      // R6: enabled input interrupt.
      intrIn <= 1'b1;
    end else if (rdA) begin
      // R9: read drops interrupt.
      intrIn <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intrOut <= 1'b0;
    end else if (modeSet) begin
      intrOut <= 1'b0;
    end else if (ackRise && latchC[PC_ACK]) begin
      intrOut <= 1'b1;
    end else if (wrA) begin
      intrOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive.

  // R10: acknowledge drives bus.
  assign portADrive  = (modeA == MODE_BIDIR) ? !pinsC[PC_ACK] : !aIn;
  assign portAOut    = latchA;
  assign portAOutEnN = {DATA_W{!portADrive}};
  // R2: plain port B drive.
  assign portBOut    = latchB;
  assign portBOutEnN = {DATA_W{bIn}};

  // Handshake modes take over port C bit 3, bits 4-5 for input and bits 6-7 for output, as status and strobe lines.
  always_comb begin
    pcDrive = {{HALF_W{!cuIn}}, {HALF_W{!clIn}}};
    pcOut   = latchC;
    if (modeA != MODE_BASIC) begin
      pcDrive[PC_INTR] = 1'b1;
      pcOut[PC_INTR]   = intrIn || intrOut;
    end
    if (hsIn) begin
      pcDrive[PC_STB]     = 1'b0;
      pcDrive[PC_IN_FULL] = 1'b1;
      pcOut[PC_IN_FULL]   = inputBufferFull;
    end
    if (hsOut) begin
      pcDrive[PC_ACK]      = 1'b0;
      pcDrive[PC_OUT_FULL] = 1'b1;
      pcOut[PC_OUT_FULL]   = outputBufferFullN;
    end
  end

  assign portCOut    = pcOut;
  assign portCOutEnN = ~pcDrive;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_comb begin
    // R14: status in port C.
    readC = (pcOut & pcDrive) | (pinsC & ~pcDrive);
    if (hsIn) begin
      readC[PC_STB] = latchC[PC_STB];
    end
    if (hsOut) begin
      readC[PC_ACK] = latchC[PC_ACK];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      readData <= LATCH_RESET;
    end else if (sel && readStrobe) begin
      unique case (regAddr)
        ADDR_PORTA: begin
          // R16: input latch read.
          readData <= hsIn ? inLatchA : (aIn ? pinsA : latchA);
        end
        ADDR_PORTB: readData <= bIn ? pinsB : latchB;
        ADDR_PORTC: readData <= readC;
        ADDR_CTRL:  readData <= ctrl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_ctrl_write;
    modeSet |=> ctrl == $past(writeData);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control word not stored"); // R4

  property p_mode0_read;
    rdA && modeA == MODE_BASIC && aIn |=> readData == $past(pinsA, 1);
  endproperty
  a_mode0_read: assert property (p_mode0_read) else $error("mode 0 read not pins"); // R2

  property p_bit_cmd;
    bitCmd |=> ((latchC ^ $past(latchC)) & ~$past(bitMask)) == LATCH_RESET
      && ((latchC & $past(bitMask)) != LATCH_RESET) == $past(writeData[BSR_VAL]);
  endproperty
  a_bit_cmd: assert property (p_bit_cmd) else $error("bit command touched wrong bits"); // R3

  property p_strobe_latch;
    stbFall |=> inputBufferFull && inLatchA == $past(pinsA);
  endproperty
  a_strobe_latch: assert property (p_strobe_latch) else $error("strobe did not latch"); // R5

  property p_intr_set;
    stbFall && latchC[PC_STB] && !modeSet |=> portCOut[PC_INTR] && !portCOutEnN[PC_INTR];
  endproperty
  a_intr_set: assert property (p_intr_set) else $error("interrupt not raised"); // R6

  property p_read_a;
    rdA && hsIn && !stbFall |=> !inputBufferFull && !intrIn && readData == $past(inLatchA);
  endproperty
  a_read_a: assert property (p_read_a) else $error("port A read wrong or flags kept"); // R16

  property p_ack_drive;
    modeA == MODE_BIDIR && !pinsC[PC_ACK] |-> portAOutEnN == LATCH_RESET && portAOut == latchA;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge did not drive port A"); // R10

  property p_out_full_low;
    wrA && hsOut |=> !outputBufferFullN ##0 !portCOut[PC_OUT_FULL];
  endproperty
  a_out_full_low: assert property (p_out_full_low) else $error("output full flag not low"); // R12

  property p_out_full_high;
    ackFall && !wrA |=> outputBufferFullN;
  endproperty
  a_out_full_high: assert property (p_out_full_high) else $error("acknowledge did not empty buffer"); // R13

  property p_status_c;
    rdC && modeA == MODE_BIDIR |=> readData[PC_OUT_FULL] == $past(outputBufferFullN)
      && readData[PC_IN_FULL] == $past(inputBufferFull);
  endproperty
  a_status_c: assert property (p_status_c) else $error("port C status bits wrong"); // R14

  c_strobe_read: cover property (stbFall ##[1:50] rdA);
  c_write_ack:   cover property (wrA && hsOut ##[1:50] ackFall);
  c_bit_cmd:     cover property (bitCmd && writeData[BSR_VAL]);

endmodule

// ===== tb/far_party_model.sv
// Far-party model: a peripheral or slave processor on port A with strobe on port C bit 4
// and acknowledge on port C bit 6. Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module far_party_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] portAOut,
  input  wire logic [7:0] portAOutEnN,
  input  wire logic [7:0] portCOut,
  input  wire logic [7:0] cOther,
  output logic      [7:0] portAIn,
  output logic      [7:0] portCIn
);
  logic [7:0] busVal = 8'h00;
  logic       stbN   = 1'b1;
  logic       ackN   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // The wire shows the device where it drives, our own value elsewhere.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      portAIn[i] = portAOutEnN[i] ? busVal[i] : portAOut[i];
    end
    portCIn    = cOther;
    portCIn[4] = stbN;
    portCIn[6] = ackN;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic setPins(input logic [7:0] d);
    @(posedge sys_clk);
    busVal <= d;
  endtask

  // wait while full. strobe with setup and hold.
  task automatic sendByte(input logic [7:0] d);
    int n;
    n = 0;
    while (portCOut[5] === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    busVal <= d;
    stbN   <= 1'b0;
    repeat (6) @(posedge sys_clk);
    stbN   <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Hold time over, so the bus no longer shows the byte.
    busVal <= ~d;
  endtask

  // acknowledge held until the device drives, and three cycles at least.
  task automatic takeByte(output logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    ackN <= 1'b0;
    while (portAOutEnN[0] !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (3) @(posedge sys_clk);
    d = portAIn;
    ackN <= 1'b1;
  endtask
endmodule

// ===== tb/tb_parallel_port_handshake.sv
// Self-checking bench for the three-port parallel interface in modes 0, 1 and 2.
// Assumes the far-party model on port A and the strobe register port of the package.
`timescale 1ns/1ps
module tb_parallel_port_handshake;
  import parallel_interface_pkg::*;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] pins;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] expRead;
    logic [DATA_W-1:0] expOut;
  } row_s;

  logic              sys_clk     = 1'b0;
  logic              resetn      = 1'b0;
  logic              chipSelN    = 1'b0;
  logic [ADDR_W-1:0] regAddr     = 2'h0;
  logic [DATA_W-1:0] writeData   = 8'h00;
  logic              writeStrobe = 1'b0;
  logic              readStrobe  = 1'b0;
  logic [DATA_W-1:0] portBIn     = 8'h77;
  logic [DATA_W-1:0] cOther      = 8'h00;
  logic [DATA_W-1:0] readData;
  logic [DATA_W-1:0] portAIn;
  logic [DATA_W-1:0] portAOut;
  logic [DATA_W-1:0] portAOutEnN;
  logic [DATA_W-1:0] portBOut;
  logic [DATA_W-1:0] portBOutEnN;
  logic [DATA_W-1:0] portCIn;
  logic [DATA_W-1:0] portCOut;
  logic [DATA_W-1:0] portCOutEnN;
  logic [DATA_W-1:0] expC;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] outSeen;
  int                errCount    = 0;
  int                numChecks   = 0;
  row_s              rows [3];

  always #50 sys_clk = ~sys_clk;

  parallel_port_handshake parallel_port_handshake_i (
    .sys_clk(sys_clk), .resetn(resetn), .chipSelN(chipSelN), .regAddr(regAddr),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .portAIn(portAIn), .portAOut(portAOut), .portAOutEnN(portAOutEnN),
    .portBIn(portBIn), .portBOut(portBOut), .portBOutEnN(portBOutEnN),
    .portCIn(portCIn), .portCOut(portCOut), .portCOutEnN(portCOutEnN)
  );

  far_party_model far_party_model_i (
    .sys_clk(sys_clk), .portAOut(portAOut), .portAOutEnN(portAOutEnN), .portCOut(portCOut),
    .cOther(cOther), .portAIn(portAIn), .portCIn(portCIn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endSim;
    $display("checks=%0d errors=%0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; read data are taken in the cycle after the strobe.
  task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    writeStrobe <= wr;
    readStrobe  <= ~wr;
    regAddr     <= a;
    writeData   <= d;
    @(posedge sys_clk);
    writeStrobe <= 1'b0;
    readStrobe  <= 1'b0;
    #1;
    q = readData;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q & m, exp);
  endtask

  task automatic waitC(input int b, input logic v);
    int n;
    n = 0;
    while (portCOut[b] !== v && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    check({7'h00, portCOut[b]}, {7'h00, v});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{ADDR_PORTA, 8'h3c, 8'hff, 8'h3c, 8'hff};
    rows[1] = '{ADDR_PORTB, 8'h00, 8'ha5, 8'ha5, 8'ha5};
    rows[2] = '{ADDR_PORTC, 8'h00, 8'h5a, 8'h5a, 8'h5a};
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    check(portAOutEnN, 8'hff);
    check(portCOut, 8'h00);
    rdChk(ADDR_CTRL, 8'hff, CTRL_RESET);
    rdChk(ADDR_PORTB, 8'hff, 8'h77);
    rdChk(ADDR_PORTC, 8'hff, 8'h50);
    wr(ADDR_CTRL, 8'h90);
    check(portBOutEnN, 8'h00);
    check(portCOutEnN, 8'h00);
    for (int i = 0; i < 3; i++) begin
      far_party_model_i.setPins(rows[i].pins);
      repeat (3) @(posedge sys_clk);
      wr(rows[i].addr, rows[i].wdata);
      rdChk(rows[i].addr, 8'hff, rows[i].expRead);
      outSeen = (rows[i].addr == ADDR_PORTB) ? portBOut : (rows[i].addr == ADDR_PORTC) ? portCOut : portAOutEnN;
      check(outSeen, rows[i].expOut);
    end
    // Deselected write must leave port B alone.
    @(posedge sys_clk);
    chipSelN <= 1'b1;
    wr(ADDR_PORTB, 8'h00);
    @(posedge sys_clk);
    chipSelN <= 1'b0;
    check(portBOut, 8'ha5);
    // Toggle each port C bit in turn; the first word is 01.
    expC = 8'h5a;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, {4'h0, i[2:0], ~expC[i]});
      expC[i] = ~expC[i];
      check(portCOut, expC);
    end
    wr(ADDR_CTRL, 8'hb0);
    wr(ADDR_CTRL, 8'h09);
    far_party_model_i.sendByte(8'h6e);
    waitC(PC_IN_FULL, 1'b1);
    check({7'h00, portCOut[PC_INTR]}, 8'h01);
    wr(ADDR_PORTB, 8'h11);
    check(portBOut, 8'h11);
    check(portBOutEnN, 8'h00);
    rdChk(ADDR_PORTA, 8'hff, 8'h6e);
    check({7'h00, portCOut[PC_INTR]}, 8'h00);
    wr(ADDR_CTRL, 8'hc0);
    wr(ADDR_PORTA, 8'h81);
    check({7'h00, portCOut[PC_OUT_FULL]}, 8'h00);
    rdChk(ADDR_PORTC, 8'ha0, 8'h00);
    far_party_model_i.sendByte(8'h42);
    waitC(PC_IN_FULL, 1'b1);
    rdChk(ADDR_PORTC, 8'ha0, 8'h20);
    far_party_model_i.takeByte(got);
    check(got, 8'h81);
    waitC(PC_OUT_FULL, 1'b1);
    rdChk(ADDR_PORTA, 8'hff, 8'h42);
    check({7'h00, portCOut[PC_IN_FULL]}, 8'h00);
    repeat (5) @(posedge sys_clk);
    check(portAOutEnN, 8'hff);
    // Mode 1 output: port A drives at once and the acknowledge empties the buffer.
    wr(ADDR_CTRL, 8'ha0);
    wr(ADDR_PORTA, 8'h5c);
    check(portAOutEnN, 8'h00);
    check(portAOut, 8'h5c);
    far_party_model_i.takeByte(got);
    check(got, 8'h5c);
    waitC(PC_OUT_FULL, 1'b1);
    // Short reset in mid-run brings back the reset state.
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (RESET_MIN_CYCLES) @(posedge sys_clk);
    resetn <= 1'b1;
    rdChk(ADDR_CTRL, 8'hff, CTRL_RESET);
    check(portCOut, 8'h00);
    endSim;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    errCount++;
    endSim;
  end
endmodule
